// file: verilog/ilvpc_consts.vh
// constants for the image loader and vocoder port controller
`ifndef ILVPC_CONSTS_VH
`define ILVPC_CONSTS_VH
`define ILVPC_ADDR_GRESET 8'h01
`define ILVPC_ADDR_OUT_GAIN 8'hb0
`define ILVPC_ADDR_IN_ROUTE 8'hb1
`define ILVPC_ADDR_PWR_DOWN 8'hc0
`define ILVPC_ADDR_MODEM_CTRL 8'hc1
`define ILVPC_ADDR_TX_AUX 8'hc2
`define ILVPC_ADDR_VOC_GAIN 8'hc3
`define ILVPC_ADDR_STATUS 8'hc6
`define ILVPC_ADDR_MODEM_CFG 8'hc7
`define ILVPC_ADDR_PROG_WORD 8'hc8
`define ILVPC_ADDR_IRQ_MASK 8'hce
`define ILVPC_ST_PRG 0
`define ILVPC_ST_VOC_FOUND 1
`define ILVPC_ST_PUSH_DONE 2
`define ILVPC_ST_IRQ 15
`define ILVPC_RD_CLEAR_MASK 15'h7ffe
`define ILVPC_ROUTE_EXT_VOC 0
`define ILVPC_PD_BIAS 0
`define ILVPC_MODE_IDLE 4'h0
`define ILVPC_MODE_RX 4'h1
`define ILVPC_MODE_TX 4'h2
`define ILVPC_BOOT_MEM 2'b01
`define ILVPC_MEM_READ_CMD 8'h03
`define ILVPC_VOC_REG_CFG 8'h10
`define ILVPC_VOC_REG_PWR 8'h11
`define ILVPC_VOC_REG_GAIN 8'h12
`define ILVPC_VOC_REG_POLL 8'h13
`define ILVPC_VOC_SLEEP 16'h0001
`define ILVPC_VOC_WAKE 16'h0000
`define ILVPC_VOC_ABSENT 16'hffff
`define ILVPC_VOC_DEFAULT 16'h02bf
`define ILVPC_VOC_FORBIDDEN 16'h1c00
`define ILVPC_VOC_I2S_BIT 13
`define ILVPC_IMAGE_WORDS 23552
`define ILVPC_AUX_HALF 4
`endif

// file: verilog/ilvpc_aux_shift.v
// one serial transfer on the auxiliary port, msb first, sampled on the rising clock edge
`timescale 1ns/10ps
module ilvpc_aux_shift #(
   parameter HALF = 4
) (
   input wire clk,
   input wire rst,
   input wire start,
   input wire [5:0] nbits,
   input wire [31:0] tx,
   input wire miso,
   output reg sclk_reg,
   output reg mosi_reg,
   output reg busy_reg,
   output reg done_reg,
   output reg [15:0] rx_reg
);
   reg [31:0] sh_reg;
   reg [5:0] cnt_reg;
   reg [7:0] ph_reg;
   always @(posedge clk) begin
      done_reg <= 1'b0;
      if (rst) begin
         sclk_reg <= 1'b0;
         mosi_reg <= 1'b0;
         busy_reg <= 1'b0;
         rx_reg <= 16'h0000;
         sh_reg <= 32'h00000000;
         cnt_reg <= 6'h00;
         ph_reg <= 8'h00;
      end else if (!busy_reg) begin
         if (start) begin
            busy_reg <= 1'b1;
            sh_reg <= tx;
            mosi_reg <= tx[31];
            cnt_reg <= nbits;
            ph_reg <= 8'h00;
         end
      end else if (ph_reg != HALF[7:0] - 8'h01) begin
         ph_reg <= ph_reg + 8'h01;
      end else begin
         ph_reg <= 8'h00;
         sclk_reg <= ~sclk_reg;
         if (!sclk_reg) begin
            rx_reg <= {rx_reg[14:0], miso};
         end else begin
            sh_reg <= {sh_reg[30:0], 1'b0};
            mosi_reg <= sh_reg[30];
            cnt_reg <= cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
         end
      end
   end
endmodule

// file: verilog/ilvpc_top.v
// image loader, host register port and auxiliary vocoder port sequencer
`timescale 1ns/10ps
`include "ilvpc_consts.vh"
module ilvpc_top #(
   parameter IMAGE_WORDS = `ILVPC_IMAGE_WORDS,
   parameter AUX_HALF = `ILVPC_AUX_HALF
) (
   input wire CLK,
   input wire RESET_N,
   input wire BUS_SELECT_N,
   input wire BUS_SCLK,
   input wire COMMAND_SERIAL_IN,
   output reg REPLY_DATA_O,
   output reg REPLY_DATA_OE_N,
   output reg HOST_INTERRUPT_LINE_N,
   input wire [1:0] BOOT_SOURCE_SELECT_PINS,
   input wire RX_IQ_MODE_STRAP,
   input wire MEM_WIDE_ADDR_STRAP,
   output reg AUX_PORT_CLOCK,
   output reg AUX_PORT_DATA_OUT,
   input wire AUX_PORT_DATA_RETURN,
   output reg BOOT_MEMORY_SELECT_N,
   output reg VOCODER_CHIP_SELECT_N,
   output reg [15:0] IMAGE_WORD,
   output reg IMAGE_WORD_VALID,
   output reg BOOT_DONE,
   output reg CLOCK_FAST,
   output reg [3:0] MODEM_MODE,
   output reg [14:0] ANALOG_BLOCK_EN,
   output reg [15:0] CODEC_RX_WORD
);
   localparam S_BOOTSEL = 4'h0, S_MEM_CMD = 4'h1, S_MEM_WORD = 4'h2, S_HOST = 4'h3, S_ACT = 4'h4;
   localparam S_POLL = 4'h5, S_PUSH = 4'h6, S_PWR = 4'h7, S_READY = 4'h8, S_GAIN = 4'h9, S_I2S = 4'ha;
   localparam S_WAIT = 4'hb;
   reg csn_s1_reg, csn_s2_reg, sck_s1_reg, sck_s2_reg, sck_d_reg, cd_s1_reg, cd_s2_reg;
   reg ret_s1_reg, ret_s2_reg, iq_s1_reg, iq_s2_reg, wide_s1_reg, wide_s2_reg;
   reg [1:0] boot_s1_reg, boot_s2_reg;
   reg greset_reg;
   reg [5:0] bit_cnt_reg;
   reg [22:0] sh_in_reg;
   reg [7:0] addr_reg;
   reg [15:0] rd_sh_reg;
   reg [15:0] out_gain_reg, route_reg, pwr_down_reg, modem_ctrl_reg, tx_aux_reg, voc_gain_reg;
   reg [15:0] modem_cfg_reg, mask_reg, prog_word_reg;
   reg [14:0] flags_reg;
   reg irq_reg;
   reg [3:0] state_reg, ret_state_reg;
   reg [15:0] word_cnt_reg;
   reg act_cnt_reg, voc_present_reg, push_pend_reg, gain_pend_reg, i2s_pend_reg, prog_pend_reg;
   reg mem_iq_reg;
   reg [15:0] settings_reg;
   reg aux_start_reg;
   reg [5:0] aux_nbits_reg;
   reg [31:0] aux_tx_reg;
   wire rst = ~RESET_N | greset_reg;
   wire sck_rise = sck_s2_reg & ~sck_d_reg & ~csn_s2_reg;
   wire sck_fall = ~sck_s2_reg & sck_d_reg & ~csn_s2_reg;
   wire addr_done = sck_rise & (bit_cnt_reg == 6'd7);
   wire wr_done = sck_rise & (bit_cnt_reg == 6'd23) & ~addr_reg[7] | sck_rise & (bit_cnt_reg == 6'd23) & (addr_reg != `ILVPC_ADDR_STATUS);
   wire [15:0] wr_data = {sh_in_reg[14:0], cd_s2_reg};
   wire [7:0] addr_now = {sh_in_reg[6:0], cd_s2_reg};
   wire status_rd = addr_done & (addr_now == `ILVPC_ADDR_STATUS);
   wire wr_prog = wr_done & (addr_reg == `ILVPC_ADDR_PROG_WORD);
   wire wr_mode = wr_done & (addr_reg == `ILVPC_ADDR_MODEM_CTRL);
   wire wr_gain = wr_done & (addr_reg == `ILVPC_ADDR_VOC_GAIN);
   wire wr_txaux = wr_done & (addr_reg == `ILVPC_ADDR_TX_AUX);
   wire wr_mask = wr_done & (addr_reg == `ILVPC_ADDR_IRQ_MASK);
   wire aux_sclk, aux_mosi, aux_busy, aux_done;
   wire [15:0] aux_rx;
   wire voc_ok = voc_present_reg & ~route_reg[`ILVPC_ROUTE_EXT_VOC];
   wire in_rxtx = (modem_ctrl_reg[3:0] == `ILVPC_MODE_RX) | (modem_ctrl_reg[3:0] == `ILVPC_MODE_TX);
   wire in_idle = modem_ctrl_reg[3:0] == `ILVPC_MODE_IDLE;
   reg prg_set, voc_set, push_set;
   reg [14:0] flags_next;
   reg [15:0] mask_next;
   reg irq_next;

   ilvpc_aux_shift #(
      .HALF(AUX_HALF)
   ) u_shift (
      .clk(CLK),
      .rst(rst),
      .start(aux_start_reg),
      .nbits(aux_nbits_reg),
      .tx(aux_tx_reg),
      .miso(ret_s2_reg),
      .sclk_reg(aux_sclk),
      .mosi_reg(aux_mosi),
      .busy_reg(aux_busy),
      .done_reg(aux_done),
      .rx_reg(aux_rx)
   );

   // pins from outside cross on two flops, except RESET_N
   always @(posedge CLK) begin
      csn_s1_reg <= BUS_SELECT_N;
      csn_s2_reg <= csn_s1_reg;
      sck_s1_reg <= BUS_SCLK;
      sck_s2_reg <= sck_s1_reg;
      sck_d_reg <= sck_s2_reg;
      cd_s1_reg <= COMMAND_SERIAL_IN;
      cd_s2_reg <= cd_s1_reg;
      ret_s1_reg <= AUX_PORT_DATA_RETURN;
      ret_s2_reg <= ret_s1_reg;
      boot_s1_reg <= BOOT_SOURCE_SELECT_PINS;
      boot_s2_reg <= boot_s1_reg;
      iq_s1_reg <= RX_IQ_MODE_STRAP;
      iq_s2_reg <= iq_s1_reg;
      wide_s1_reg <= MEM_WIDE_ADDR_STRAP;
      wide_s2_reg <= wide_s1_reg;
   end

   // flag and interrupt next values; a set in the same cycle as a clear wins
   always @* begin
      mask_next = wr_mask ? wr_data : mask_reg;
      flags_next = flags_reg;
      if (status_rd) begin
         flags_next = flags_next & ~`ILVPC_RD_CLEAR_MASK;
      end
      if (wr_prog) begin
         flags_next[`ILVPC_ST_PRG] = 1'b0;
      end
      if (prg_set) begin
         flags_next[`ILVPC_ST_PRG] = 1'b1;
      end
      if (voc_set) begin
         flags_next[`ILVPC_ST_VOC_FOUND] = 1'b1;
      end
      if (push_set) begin
         flags_next[`ILVPC_ST_PUSH_DONE] = 1'b1;
      end
      irq_next = irq_reg & ~status_rd;
      if (|(((flags_next & ~flags_reg) | (mask_next[14:0] & ~mask_reg[14:0])) & flags_next & mask_next[14:0])) begin
         irq_next = 1'b1;
      end
   end

   // host register port
   always @(posedge CLK) begin
      greset_reg <= 1'b0;
      if (!RESET_N) begin
         greset_reg <= 1'b0;
      end else if (addr_done & (addr_now == `ILVPC_ADDR_GRESET)) begin
         greset_reg <= 1'b1;
      end
      if (rst) begin
         bit_cnt_reg <= 6'h00;
         sh_in_reg <= 23'h000000;
         addr_reg <= 8'h00;
         rd_sh_reg <= 16'h0000;
         REPLY_DATA_O <= 1'b0;
         REPLY_DATA_OE_N <= 1'b1;
         out_gain_reg <= 16'h0000;
         route_reg <= 16'h0000;
         pwr_down_reg <= 16'h0000;
         modem_ctrl_reg <= 16'h0000;
         tx_aux_reg <= 16'h0000;
         voc_gain_reg <= 16'h0000;
         modem_cfg_reg <= 16'h0000;
         mask_reg <= 16'h0000;
         prog_word_reg <= 16'h0000;
         flags_reg <= 15'h0000;
         irq_reg <= 1'b0;
         HOST_INTERRUPT_LINE_N <= 1'b1;
         ANALOG_BLOCK_EN <= 15'h0000;
      end else begin
         flags_reg <= flags_next;
         irq_reg <= irq_next;
         mask_reg <= mask_next;
         // line low when summary and mask set
         HOST_INTERRUPT_LINE_N <= ~(irq_next & mask_next[`ILVPC_ST_IRQ]);
         ANALOG_BLOCK_EN <= pwr_down_reg[`ILVPC_PD_BIAS] ? pwr_down_reg[15:1] : 15'h0000;
         if (csn_s2_reg) begin
            bit_cnt_reg <= 6'h00;
            REPLY_DATA_OE_N <= 1'b1;
         end
         if (sck_rise) begin
            sh_in_reg <= {sh_in_reg[21:0], cd_s2_reg};
            if (bit_cnt_reg != 6'h3f) begin
               bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
         end
         if (addr_done) begin
            addr_reg <= addr_now;
            if (addr_now == `ILVPC_ADDR_STATUS) begin
               rd_sh_reg <= {irq_reg, flags_reg};
               REPLY_DATA_O <= irq_reg;
               REPLY_DATA_OE_N <= 1'b0;
            end
         end
         if (sck_fall & ~REPLY_DATA_OE_N & (bit_cnt_reg > 6'd8)) begin
            rd_sh_reg <= {rd_sh_reg[14:0], 1'b0};
            REPLY_DATA_O <= rd_sh_reg[14];
         end
         if (wr_done) begin
            case (addr_reg)
               `ILVPC_ADDR_OUT_GAIN: out_gain_reg <= wr_data;
               `ILVPC_ADDR_IN_ROUTE: route_reg <= wr_data;
               `ILVPC_ADDR_PWR_DOWN: pwr_down_reg <= wr_data;
               `ILVPC_ADDR_MODEM_CTRL: modem_ctrl_reg <= wr_data;
               `ILVPC_ADDR_TX_AUX: tx_aux_reg <= wr_data;
               `ILVPC_ADDR_VOC_GAIN: voc_gain_reg <= wr_data;
               `ILVPC_ADDR_MODEM_CFG: modem_cfg_reg <= wr_data;
               `ILVPC_ADDR_PROG_WORD: prog_word_reg <= wr_data;
               default: ;
            endcase
         end
      end
   end

   // boot, activation and auxiliary port sequencer
   always @(posedge CLK) begin
      aux_start_reg <= 1'b0;
      IMAGE_WORD_VALID <= 1'b0;
      prg_set <= 1'b0;
      voc_set <= 1'b0;
      push_set <= 1'b0;
      if (rst) begin
         state_reg <= S_BOOTSEL;
         ret_state_reg <= S_READY;
         word_cnt_reg <= 16'h0000;
         act_cnt_reg <= 1'b0;
         voc_present_reg <= 1'b0;
         push_pend_reg <= 1'b0;
         gain_pend_reg <= 1'b0;
         i2s_pend_reg <= 1'b0;
         prog_pend_reg <= 1'b0;
         mem_iq_reg <= 1'b0;
         settings_reg <= `ILVPC_VOC_DEFAULT;
         aux_nbits_reg <= 6'h00;
         aux_tx_reg <= 32'h00000000;
         IMAGE_WORD <= 16'h0000;
         BOOT_DONE <= 1'b0;
         CLOCK_FAST <= 1'b0;
         MODEM_MODE <= `ILVPC_MODE_IDLE;
         BOOT_MEMORY_SELECT_N <= 1'b1;
         VOCODER_CHIP_SELECT_N <= 1'b1;
         AUX_PORT_CLOCK <= 1'b0;
         AUX_PORT_DATA_OUT <= 1'b0;
         CODEC_RX_WORD <= 16'h0000;
      end else begin
         AUX_PORT_CLOCK <= aux_sclk;
         AUX_PORT_DATA_OUT <= aux_mosi;
         MODEM_MODE <= modem_ctrl_reg[3:0];
         // clock follows the mode once boot is done, even mid-transfer
         CLOCK_FAST <= BOOT_DONE & in_rxtx;
         if (wr_prog) begin
            prog_pend_reg <= 1'b1;
         end
         if (wr_mode & BOOT_DONE) begin
            push_pend_reg <= 1'b1;
         end
         // gain forwarded only in rx or tx
         if (wr_gain & in_rxtx) begin
            gain_pend_reg <= 1'b1;
         end
         // codec words only in rx or tx
         if (wr_txaux & in_rxtx & settings_reg[`ILVPC_VOC_I2S_BIT]) begin
            i2s_pend_reg <= 1'b1;
         end
         case (state_reg)
            S_BOOTSEL: begin
               // pins taken once after reset release
               mem_iq_reg <= iq_s2_reg;
               if (boot_s2_reg == `ILVPC_BOOT_MEM && !iq_s2_reg) begin
                  BOOT_MEMORY_SELECT_N <= 1'b0;
                  aux_nbits_reg <= wide_s2_reg ? 6'd32 : 6'd24;
                  aux_tx_reg <= {`ILVPC_MEM_READ_CMD, 24'h000000};
                  aux_start_reg <= 1'b1;
                  state_reg <= S_MEM_CMD;
               end else begin
                  state_reg <= S_HOST;
               end
            end
            S_MEM_CMD: begin
               if (aux_done) begin
                  aux_nbits_reg <= 6'd16;
                  aux_start_reg <= 1'b1;
                  state_reg <= S_MEM_WORD;
               end
            end
            S_MEM_WORD: begin
               if (aux_done) begin
                  IMAGE_WORD <= aux_rx;
                  IMAGE_WORD_VALID <= 1'b1;
                  word_cnt_reg <= word_cnt_reg + 16'h0001;
                  if (word_cnt_reg == IMAGE_WORDS[15:0] - 16'h0001) begin
                     BOOT_MEMORY_SELECT_N <= 1'b1;
                     state_reg <= S_ACT;
                  end else begin
                     aux_start_reg <= 1'b1;
                  end
               end
            end
            S_HOST: begin
               // image words arrive by programming register
               if (prog_pend_reg) begin
                  prog_pend_reg <= 1'b0;
                  IMAGE_WORD <= prog_word_reg;
                  IMAGE_WORD_VALID <= 1'b1;
                  prg_set <= 1'b1;
                  word_cnt_reg <= word_cnt_reg + 16'h0001;
                  if (word_cnt_reg == IMAGE_WORDS[15:0] - 16'h0001) begin
                     state_reg <= S_ACT;
                  end
               end
            end
            S_ACT: begin
               if (prog_pend_reg) begin
                  prog_pend_reg <= 1'b0;
                  prg_set <= 1'b1;
                  act_cnt_reg <= 1'b1;
                  if (act_cnt_reg) begin
                     if (route_reg[`ILVPC_ROUTE_EXT_VOC]) begin
                        state_reg <= S_READY;
                        BOOT_DONE <= 1'b1;
                     end else begin
                        // memory select off, vocoder select live
                        BOOT_DONE <= 1'b1;
                        // vocoder has a select of its own
                        VOCODER_CHIP_SELECT_N <= 1'b0;
                        aux_nbits_reg <= 6'd24;
                        aux_tx_reg <= {`ILVPC_VOC_REG_POLL, 24'h000000};
                        aux_start_reg <= 1'b1;
                        state_reg <= S_POLL;
                     end
                  end
               end
            end
            S_POLL: begin
               if (aux_done) begin
                  VOCODER_CHIP_SELECT_N <= 1'b1;
                  voc_present_reg <= (aux_rx != `ILVPC_VOC_ABSENT);
                  voc_set <= (aux_rx != `ILVPC_VOC_ABSENT);
                  push_pend_reg <= 1'b1;
                  state_reg <= S_READY;
               end
            end
            S_READY: begin
               // block writes accepted in idle only
               if (prog_pend_reg & in_idle) begin
                  prog_pend_reg <= 1'b0;
                  // tone two, dtx and vad stripped
                  settings_reg <= prog_word_reg & ~`ILVPC_VOC_FORBIDDEN;
                  prg_set <= 1'b1;
               end else if (push_pend_reg & voc_ok) begin
                  push_pend_reg <= 1'b0;
                  VOCODER_CHIP_SELECT_N <= 1'b0;
                  aux_nbits_reg <= 6'd24;
                  aux_tx_reg <= {`ILVPC_VOC_REG_CFG, settings_reg & ~`ILVPC_VOC_FORBIDDEN, 8'h00};
                  aux_start_reg <= 1'b1;
                  state_reg <= S_PUSH;
               end else if (gain_pend_reg & voc_ok) begin
                  gain_pend_reg <= 1'b0;
                  VOCODER_CHIP_SELECT_N <= 1'b0;
                  aux_nbits_reg <= 6'd24;
                  aux_tx_reg <= {`ILVPC_VOC_REG_GAIN, voc_gain_reg, 8'h00};
                  aux_start_reg <= 1'b1;
                  state_reg <= S_GAIN;
               end else if (i2s_pend_reg) begin
                  i2s_pend_reg <= 1'b0;
                  VOCODER_CHIP_SELECT_N <= 1'b0;
                  aux_nbits_reg <= 6'd16;
                  aux_tx_reg <= {tx_aux_reg, 16'h0000};
                  aux_start_reg <= 1'b1;
                  state_reg <= S_I2S;
               end else if (!voc_ok) begin
                  // drop jobs only with no vocoder, else a request raised this cycle is lost
                  push_pend_reg <= 1'b0;
                  gain_pend_reg <= 1'b0;
               end
            end
            S_PUSH: begin
               if (aux_done) begin
                  VOCODER_CHIP_SELECT_N <= 1'b1;
                  state_reg <= S_WAIT;
                  ret_state_reg <= S_PWR;
               end
            end
            S_PWR: begin
               VOCODER_CHIP_SELECT_N <= 1'b0;
               aux_tx_reg <= {`ILVPC_VOC_REG_PWR, in_idle ? `ILVPC_VOC_SLEEP : `ILVPC_VOC_WAKE, 8'h00};
               aux_start_reg <= 1'b1;
               push_set <= 1'b1;
               state_reg <= S_GAIN;
            end
            S_GAIN, S_I2S: begin
               if (aux_done) begin
                  VOCODER_CHIP_SELECT_N <= 1'b1;
                  if (state_reg == S_I2S) begin
                     CODEC_RX_WORD <= aux_rx;
                  end
                  state_reg <= S_WAIT;
                  ret_state_reg <= S_READY;
               end
            end
            S_WAIT: begin
               // one idle cycle so the select is seen high between frames
               state_reg <= ret_state_reg;
            end
            default: state_reg <= S_BOOTSEL;
         endcase
      end
   end
endmodule

// file: verif/ilvpc_asserts.sv
// concurrent checks on the loader and vocoder port outputs
`timescale 1ns/10ps
module ilvpc_asserts (
   input wire CLK,
   input wire RESET_N,
   input wire BUS_SELECT_N,
   input wire [1:0] BOOT_SOURCE_SELECT_PINS,
   input wire RX_IQ_MODE_STRAP,
   input wire REPLY_DATA_OE_N,
   input wire BOOT_MEMORY_SELECT_N,
   input wire VOCODER_CHIP_SELECT_N,
   input wire IMAGE_WORD_VALID,
   input wire BOOT_DONE,
   input wire CLOCK_FAST,
   input wire [3:0] MODEM_MODE
);
   // boot source as seen at the last reset cycle; boot pins and iq strap only move under reset
   reg mem_boot_reg;
   reg iq_reg;
   always @(posedge CLK) begin
      if (!RESET_N) begin
         mem_boot_reg <= (BOOT_SOURCE_SELECT_PINS == 2'b01);
         iq_reg <= RX_IQ_MODE_STRAP;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   AST_VOC_CS_BOOT: assert property (!BOOT_DONE |-> VOCODER_CHIP_SELECT_N)
      else $error("vocoder select low during boot");
   AST_MEM_CS_DONE: assert property (BOOT_DONE |-> BOOT_MEMORY_SELECT_N)
      else $error("memory select low after boot");
   AST_ONE_SELECT: assert property (!BOOT_MEMORY_SELECT_N |-> VOCODER_CHIP_SELECT_N)
      else $error("both aux selects low");
   AST_NO_MEM_HOST: assert property (!mem_boot_reg |-> BOOT_MEMORY_SELECT_N)
      else $error("memory selected in host load");
   AST_NO_MEM_IQ: assert property (iq_reg |-> BOOT_MEMORY_SELECT_N)
      else $error("memory selected in iq mode");
   AST_FAST_RXTX: assert property ((BOOT_DONE && MODEM_MODE inside {4'h1, 4'h2}) [*3] |-> CLOCK_FAST)
      else $error("clock slow in rx or tx");
   AST_SLOW_IDLE: assert property ((MODEM_MODE == 4'h0) [*3] |-> !CLOCK_FAST)
      else $error("clock fast in idle");
   AST_WORD_PULSE: assert property (IMAGE_WORD_VALID |=> !IMAGE_WORD_VALID)
      else $error("image word pulse too long");
   AST_OE_IDLE: assert property (BUS_SELECT_N [*4] |-> REPLY_DATA_OE_N)
      else $error("reply driven with bus idle");
   cover property ($rose(BOOT_DONE));
   cover property (!REPLY_DATA_OE_N);
   cover property (!VOCODER_CHIP_SELECT_N ##1 VOCODER_CHIP_SELECT_N);
endmodule

bind ilvpc_top ilvpc_asserts ilvpc_asserts_inst (.CLK(CLK), .RESET_N(RESET_N), .BUS_SELECT_N(BUS_SELECT_N),
   .BOOT_SOURCE_SELECT_PINS(BOOT_SOURCE_SELECT_PINS), .RX_IQ_MODE_STRAP(RX_IQ_MODE_STRAP),
   .REPLY_DATA_OE_N(REPLY_DATA_OE_N), .BOOT_MEMORY_SELECT_N(BOOT_MEMORY_SELECT_N),
   .VOCODER_CHIP_SELECT_N(VOCODER_CHIP_SELECT_N), .IMAGE_WORD_VALID(IMAGE_WORD_VALID), .BOOT_DONE(BOOT_DONE),
   .CLOCK_FAST(CLOCK_FAST), .MODEM_MODE(MODEM_MODE));

// file: verif/ilvpc_host_model.sv
// host controller on the serial register bus
`timescale 1ns/10ps
module ilvpc_host_model (
   input wire clk,
   input wire reply,
   output reg bus_select_n,
   output reg bus_sclk,
   output reg cmd_in
);
   initial begin
      bus_select_n = 1'b1;
      bus_sclk = 1'b0;
      cmd_in = 1'b0;
   end
   // one transfer, msb first; reply taken at the end of each high phase
   task xfer(input [23:0] bits, input addr_only, output [15:0] rd);
      integer i;
      begin
         rd = 16'h0000;
         @(negedge clk);
         bus_select_n = 1'b0;
         for (i = 0; i < (addr_only ? 8 : 24); i = i + 1) begin
            bus_sclk = 1'b0;
            cmd_in = bits[23 - i];
            repeat (4) @(negedge clk);
            bus_sclk = 1'b1;
            repeat (4) @(negedge clk);
            rd = {rd[14:0], reply};
         end
         bus_sclk = 1'b0;
         repeat (4) @(negedge clk);
         bus_select_n = 1'b1;
         repeat (8) @(negedge clk);
      end
   endtask
   task prog(input [15:0] d);
      integer k;
      reg [15:0] s;
      begin
         xfer({8'hc8, d}, 1'b0, s);
         s = 16'h0000;
         for (k = 0; k < 40 && s[0] !== 1'b1; k = k + 1)
            xfer({8'hc6, 16'h0000}, 1'b0, s);
      end
   endtask
endmodule

// file: verif/tb.sv
// self-checking bench for the image loader and vocoder port controller
`timescale 1ns/10ps
`include "ilvpc_consts.vh"
module tb;
   reg clk = 1'b0;
   reg reset_n = 1'b0;
   reg [1:0] pins = 2'b11;
   reg iq = 1'b0;
   reg wide = 1'b0;
   reg tgl = 1'b0;
   reg aux_d = 1'b0;
   reg vcs_d = 1'b1;
   reg seen_cfg = 1'b0;
   reg seen_slp = 1'b0;
   reg [15:0] cfg_exp = `ILVPC_VOC_DEFAULT;
   reg [15:0] rd;
   reg [23:0] voc_sh = 24'h000000;
   reg [43:0] rows [0:6];
   integer num_errors = 0;
   integer total_checks = 0;
   integer pulses = 0;
   integer edges = 0;
   integer sels = 0;
   integer i;
   integer n;
   wire scs_n, sclk, sdi, rdo, roe_n, irq_n, aclk, ado, mcs_n, vcs_n, wv, done, fast;
   wire [15:0] word, cw;
   wire [3:0] mode;
   wire [14:0] an_en;
   // released return line toggles, memory sends ones, vocoder echoes its input
   wire aret = !vcs_n ? ado : (!mcs_n ? 1'b1 : tgl);
   always #25 clk = ~clk;
   ilvpc_top #(.IMAGE_WORDS(4), .AUX_HALF(4)) ilvpc_top_inst (.CLK(clk), .RESET_N(reset_n), .BUS_SELECT_N(scs_n),
      .BUS_SCLK(sclk), .COMMAND_SERIAL_IN(sdi), .REPLY_DATA_O(rdo), .REPLY_DATA_OE_N(roe_n),
      .HOST_INTERRUPT_LINE_N(irq_n), .BOOT_SOURCE_SELECT_PINS(pins), .RX_IQ_MODE_STRAP(iq),
      .MEM_WIDE_ADDR_STRAP(wide), .AUX_PORT_CLOCK(aclk), .AUX_PORT_DATA_OUT(ado), .AUX_PORT_DATA_RETURN(aret),
      .BOOT_MEMORY_SELECT_N(mcs_n), .VOCODER_CHIP_SELECT_N(vcs_n), .IMAGE_WORD(word), .IMAGE_WORD_VALID(wv),
      .BOOT_DONE(done), .CLOCK_FAST(fast), .MODEM_MODE(mode), .ANALOG_BLOCK_EN(an_en), .CODEC_RX_WORD(cw));
   ilvpc_host_model ilvpc_host_model_inst (.clk(clk), .reply(roe_n ? tgl : rdo), .bus_select_n(scs_n),
      .bus_sclk(sclk), .cmd_in(sdi));
   // watch the aux port: words sent to the vocoder, memory clock edges
   always @(posedge clk) begin
      tgl <= ~tgl;
      aux_d <= aclk;
      vcs_d <= vcs_n;
      if (wv === 1'b1) pulses <= pulses + 1;
      if (aclk === 1'b1 && aux_d === 1'b0 && mcs_n === 1'b0) edges <= edges + 1;
      if (aclk === 1'b1 && aux_d === 1'b0 && vcs_n === 1'b0) voc_sh <= {voc_sh[22:0], ado};
      if (vcs_n === 1'b1 && vcs_d === 1'b0) begin
         sels <= sels + 1;
         if (voc_sh === {8'h10, cfg_exp}) seen_cfg <= 1'b1;
         if (voc_sh === {8'h11, 16'h0001}) seen_slp <= 1'b1;
      end
   end
   task check(input string name, input [23:0] seen, input [23:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      ilvpc_host_model_inst.xfer({a, d}, 1'b0, rd);
   endtask
   task rst(input [1:0] p, input q, input w);
      begin
         @(negedge clk);
         reset_n = 1'b0;
         pins = p;
         iq = q;
         wide = w;
         repeat (4) @(negedge clk);
         reset_n = 1'b1;
         pulses = 0;
         edges = 0;
         sels = 0;
      end
   endtask
   task boot(input [15:0] route);
      begin
         for (i = 0; i < 4; i = i + 1)
            ilvpc_host_model_inst.prog({12'h123, i[3:0]});
         check("image", {pulses[7:0], word}, {8'd4, 16'h1233});
         wr(8'hb1, route);
         ilvpc_host_model_inst.prog(16'haaaa);
         ilvpc_host_model_inst.prog(16'h5555);
         repeat (800) @(negedge clk);
         check("poll", {done, sels != 0}, {1'b1, !route[0]});
      end
   endtask
   task wait_words;
      for (n = 0; n < 20000 && pulses < 4; n = n + 1) @(negedge clk);
   endtask
   task print_verdict;
      begin
         $display("checks %0d errors %0d", total_checks, num_errors);
         if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      #5000000;
      num_errors = num_errors + 1;
      print_verdict;
   end
   initial begin
      rows[0] = {8'hc0, 16'hfffe, 20'h00000};
      rows[1] = {8'hc0, 16'hffff, 20'h07fff};
      rows[2] = {8'hc1, 16'h0001, 20'h1ffff};
      rows[3] = {8'hc1, 16'h0000, 20'h07fff};
      rows[4] = {8'hc1, 16'h0002, 20'h2ffff};
      rows[5] = {8'hc0, 16'h0004, 20'h28000};
      rows[6] = {8'hc1, 16'h0000, 20'h00000};
      rst(2'b11, 1'b0, 1'b0);
      boot(16'h0000);
      for (i = 0; i < 7; i = i + 1) begin
         wr(rows[i][43:36], rows[i][35:20]);
         repeat (400) @(negedge clk);
         check("mode", {mode, fast, an_en}, rows[i][19:0]);
      end
      check("cfg push", seen_cfg, 1'b1);
      check("sleep", seen_slp, 1'b1);
      ilvpc_host_model_inst.prog(16'h1cbf);
      cfg_exp = 16'h00bf;
      seen_cfg = 1'b0;
      wr(8'hc1, 16'h0000);
      repeat (400) @(negedge clk);
      check("forced off", seen_cfg, 1'b1);
      for (i = 0; i < 2; i = i + 1) begin
         wr(8'hc1, {15'h0000, i[0]});
         repeat (600) @(negedge clk);
         n = sels;
         wr(8'hc3, 16'h0077);
         repeat (400) @(negedge clk);
         check("gain", sels - n, i);
      end
      // codec frame in rx once settings bit 13 selects it; the echo must return the word
      wr(8'hc1, 16'h0000);
      ilvpc_host_model_inst.prog(16'h22bf);
      wr(8'hc1, 16'h0001);
      repeat (600) @(negedge clk);
      wr(8'hc2, 16'h5a3c);
      repeat (400) @(negedge clk);
      check("codec", cw, 16'h5a3c);
      wr(8'hce, 16'h8001);
      repeat (20) @(negedge clk);
      check("irq", irq_n, 1'b0);
      wr(8'hc6, 16'h0000);
      check("status", {rd[15], rd[0], irq_n}, 3'b111);
      wr(8'hc6, 16'h0000);
      check("status again", {rd[15], rd[0]}, 2'b01);
      rst(2'b11, 1'b0, 1'b0);
      boot(16'h0001);
      rst(2'b01, 1'b0, 1'b0);
      wait_words;
      check("mem load", {pulses[7:0], word}, {8'd4, 16'hffff});
      check("narrow", edges, 88);
      wide = 1'b1;
      pulses = 0;
      edges = 0;
      ilvpc_host_model_inst.xfer({8'h01, 16'h0000}, 1'b1, rd);
      wait_words;
      check("wide", {pulses[7:0], edges[15:0]}, {8'd4, 16'd96});
      rst(2'b01, 1'b1, 1'b0);
      repeat (2000) @(negedge clk);
      check("iq", pulses + edges, 0);
      print_verdict;
   end
endmodule
